// File: input_serializer.sv
// top of the octal input serializer: pin sync, status, frame and shifter
// assumes the serial clock is far slower than the core clock (one eighth or less)
`timescale 1ns/1ns
`include "input_serializer_cfg.svh"

// What this block does
// - two select bits choose debounce time
// - filter tick is third of debounce time
// - change passes after three stable ticks
// - chip select fall captures inputs and status
// - each clock pulse shifts one bit out
// - long frame: eight inputs plus status byte
// - status: supply low, overtemp, crc, stop
// - supply low sets below off, clears above on
// - overtemp flag follows temperature alarm level
// - crc polynomial x5 plus x4 plus x2 plus 1
// - length select high eight, low sixteen
// - short mode sends inputs only
// - serial input never alters internal state
// - cascade input fills shift register tail
// - fault low on overtemp or supply low
// - supply fault releases only above on threshold
// - msb first, first bit on select fall
// - later bits change on clock falling edge
// - serial output released while select high
// - order: inputs, crc, supply, temp, stop
module input_serializer #(
    parameter int unsigned TICK1_CYC = `DEB1_TICK_CYC,
    parameter int unsigned TICK2_CYC = `DEB2_TICK_CYC,
    parameter int unsigned TICK3_CYC = `DEB3_TICK_CYC,
    parameter int BUF_DEPTH = 2
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [7:0] field_inputs_i,
    input wire logic debounce_sel_lo_i,
    input wire logic debounce_sel_hi_i,
    input wire logic frame_length_select_i,
    input wire logic supply_below_off_i,
    input wire logic supply_above_on_i,
    input wire logic temp_alarm_i,
    input wire logic chip_sel_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_cascade_in_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic fault_n_o,
    output logic supply_low_flag_o,
    output logic over_temp_flag_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [`PIN_W-1:0] s1;
        logic [`PIN_W-1:0] s2;
        logic [`PIN_W-1:0] s3;
        logic [`PIN_W-1:0] lvl;
        input_serializer_pkg::link_state_t state;
        logic [`FRAME_W-1:0] sr;
        logic casc_hold;
        logic [7:0] filt;
        logic supply_low;
        logic over_temp;
        logic ser_bit;
        logic oe;
        logic fault_n;
    } top_state_t;

    top_state_t r;
    top_state_t n;
    logic [`PIN_W-1:0] pins;
    logic [`PIN_W-1:0] lvl_nxt;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic mode8;
    logic [7:0] db_word;
    logic db_valid;
    logic db_ready;
    logic buf_valid;
    logic [7:0] buf_word;
    logic buf_ready;
    logic [`FRAME_W-1:0] frame;

    // ----------------------------------------
    // crc over the latched inputs
    // ----------------------------------------
    function automatic logic [4:0] crc5(input logic [7:0] d);
        logic [4:0] c;
        logic fb;
        c = '0;
        for (int i = 7; i >= 0; i--) begin
            fb = c[4] ^ d[i];
            c = {c[3:0], 1'b0};
            if (fb) begin
                c = c ^ `CRC_POLY;
            end
        end
        return c;
    endfunction

    // ----------------------------------------
    // pin synchroniser: a level counts once stages two and three agree
    // ----------------------------------------
    assign pins = {debounce_sel_hi_i, debounce_sel_lo_i, frame_length_select_i,
                   temp_alarm_i, supply_above_on_i, supply_below_off_i,
                   serial_cascade_in_i, serial_clk_i, chip_sel_n_i};
    assign lvl_nxt = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.lvl);
    assign cs_fall = r.lvl[`PIN_CS] && !lvl_nxt[`PIN_CS];
    assign cs_rise = !r.lvl[`PIN_CS] && lvl_nxt[`PIN_CS];
    assign sclk_rise = !r.lvl[`PIN_SCLK] && lvl_nxt[`PIN_SCLK];
    assign sclk_fall = r.lvl[`PIN_SCLK] && !lvl_nxt[`PIN_SCLK];
    assign mode8 = r.lvl[`PIN_MODE8];

    // ----------------------------------------
    // filter and the buffer in front of the latch
    // ----------------------------------------
    debounce_filter #(
        .TICK1_CYC(TICK1_CYC),
        .TICK2_CYC(TICK2_CYC),
        .TICK3_CYC(TICK3_CYC)
    ) u_filter (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .field_inputs_i(field_inputs_i),
        .debounce_sel_i({r.lvl[`PIN_DB_HI], r.lvl[`PIN_DB_LO]}),
        .word_o(db_word),
        .valid_o(db_valid),
        .ready_i(db_ready)
    );

    word_buffer #(
        .W(8),
        .DEPTH(BUF_DEPTH)
    ) u_buffer (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .in_valid_i(db_valid),
        .in_data_i(db_word),
        .in_ready_o(db_ready),
        .out_valid_o(buf_valid),
        .out_data_o(buf_word),
        .out_ready_i(buf_ready)
    );

    // the latch view only moves while no frame runs, so a frame always
    // reports the state seen at its select fall; the buffer absorbs the wait
    assign buf_ready = r.lvl[`PIN_CS];

    // ----------------------------------------
    // frame image at select fall
    // ----------------------------------------
    always_comb begin
        if (mode8) begin
            frame = {r.filt, 8'h00};
        end else begin
            frame = {r.filt, crc5(r.filt), r.supply_low, r.over_temp, `STOP_BIT};
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = r;
        n.s1 = pins;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.lvl = lvl_nxt;
        if (buf_valid && buf_ready) begin
            n.filt = buf_word;
        end
        // supply alarm holds until the monitor reports recovery
        if (r.lvl[`PIN_BELOW_OFF]) begin
            n.supply_low = 1'b1;
        end else if (r.lvl[`PIN_ABOVE_ON]) begin
            n.supply_low = 1'b0;
        end
        n.over_temp = r.lvl[`PIN_TEMP];
        n.fault_n = !(n.supply_low || n.over_temp);
        case (r.state)
            input_serializer_pkg::LINK_IDLE: begin
                n.oe = 1'b0;
                n.ser_bit = 1'b0;
                if (cs_fall) begin
                    n.state = input_serializer_pkg::LINK_FRAME;
                    n.sr = frame;
                    n.ser_bit = frame[`FRAME_W-1];
                    n.oe = 1'b1;
                end
            end
            input_serializer_pkg::LINK_FRAME: begin
                if (cs_rise) begin
                    n.state = input_serializer_pkg::LINK_IDLE;
                    n.oe = 1'b0;
                    n.ser_bit = 1'b0;
                end else begin
                    // cascade bit is taken where the master samples; it only feeds the tail
                    if (sclk_rise) begin
                        n.casc_hold = r.lvl[`PIN_CASC];
                    end
                    if (sclk_fall) begin
                        n.sr = {r.sr[`FRAME_W-2:0], r.casc_hold};
                        if (mode8) begin
                            n.sr[8] = r.casc_hold;
                        end
                        n.ser_bit = r.sr[`FRAME_W-2];
                    end
                end
            end
            default: begin
                n.state = input_serializer_pkg::LINK_IDLE;
                n.oe = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // registers and outputs
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            r <= '0;
            r.fault_n <= 1'b1;
        end else if (ce_i) begin
            r <= n;
        end
    end

    assign serial_out_o = r.ser_bit;
    assign serial_out_oe_o = r.oe;
    assign fault_n_o = r.fault_n;
    assign supply_low_flag_o = r.supply_low;
    assign over_temp_flag_o = r.over_temp;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_FIRST_BIT_ON_FALL: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (ce_i && cs_fall && r.state == input_serializer_pkg::LINK_IDLE)
            |=> (serial_out_oe_o && serial_out_o == $past(r.filt[7])))
        else $error("first bit not presented at select fall");

    AST_RELEASED_WHEN_IDLE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        r.lvl[`PIN_CS] |-> !serial_out_oe_o)
        else $error("serial output driven while select high");

    AST_SHIFT_ON_FALL: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (ce_i && sclk_fall && !cs_rise && r.state == input_serializer_pkg::LINK_FRAME)
            |=> (serial_out_o == $past(r.sr[`FRAME_W-2])))
        else $error("next bit not shifted on clock fall");

    AST_FAULT_TRACKS_FLAGS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        fault_n_o == !(supply_low_flag_o || over_temp_flag_o))
        else $error("fault output disagrees with flags");

    AST_SUPPLY_HOLDS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (ce_i && supply_low_flag_o && !r.lvl[`PIN_ABOVE_ON]) |=> supply_low_flag_o)
        else $error("supply flag cleared without recovery");

    AST_TEMP_FOLLOWS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        ce_i |=> (over_temp_flag_o == $past(r.lvl[`PIN_TEMP])))
        else $error("overtemp flag does not follow the alarm");

    AST_LONG_FRAME_TAIL: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (ce_i && cs_fall && !mode8 && r.state == input_serializer_pkg::LINK_IDLE)
            |=> (r.sr[0] == `STOP_BIT && r.sr[7:3] == crc5(r.sr[15:8])))
        else $error("long frame tail wrong");

    AST_SHORT_FRAME_EMPTY: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (ce_i && cs_fall && mode8 && r.state == input_serializer_pkg::LINK_IDLE)
            |=> (r.sr[7:0] == 8'h00))
        else $error("short frame carries status");

    AST_LATCH_FROZEN_IN_FRAME: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (r.state == input_serializer_pkg::LINK_FRAME && !r.lvl[`PIN_CS]) |=> $stable(r.filt))
        else $error("latched inputs changed during a frame");

    AST_FRAME_HEAD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (ce_i && cs_fall && r.state == input_serializer_pkg::LINK_IDLE)
            |=> (r.sr[15:8] == $past(r.filt)))
        else $error("frame head differs from latched inputs");

    AST_SUPPLY_SETS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (ce_i && r.lvl[`PIN_BELOW_OFF]) |=> supply_low_flag_o)
        else $error("supply flag not set below the off threshold");

    AST_SUPPLY_CLEARS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (ce_i && !r.lvl[`PIN_BELOW_OFF] && r.lvl[`PIN_ABOVE_ON])
            |=> !supply_low_flag_o)
        else $error("supply flag not cleared on recovery");

    AST_SHORT_CASCADE_ENTRY: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (ce_i && sclk_fall && mode8 && !cs_rise && r.state == input_serializer_pkg::LINK_FRAME)
            |=> (r.sr[8] == $past(r.casc_hold)))
        else $error("cascade bit not placed behind the short frame");

endmodule

// File: input_serializer_cfg.svh
// constants for the octal input serializer: pin indices, frame layout, timing
// assumes a 25 MHz core clock; included by bare name
`ifndef INPUT_SERIALIZER_CFG_SVH
`define INPUT_SERIALIZER_CFG_SVH

// ----------------------------------------
// core clock
// ----------------------------------------
`define CLK_PERIOD_NS 40

// ----------------------------------------
// debounce times, tick is one third of each
// ----------------------------------------
`define DEB1_TIME_NS 25000
`define DEB2_TIME_NS 750000
`define DEB3_TIME_NS 3000000
`define TICK_DIV 3
`define DEB1_TICK_CYC (`DEB1_TIME_NS / (`TICK_DIV * `CLK_PERIOD_NS))
`define DEB2_TICK_CYC (`DEB2_TIME_NS / (`TICK_DIV * `CLK_PERIOD_NS))
`define DEB3_TICK_CYC (`DEB3_TIME_NS / (`TICK_DIV * `CLK_PERIOD_NS))
`define STABLE_TICKS 2'h3

// ----------------------------------------
// index of each pin in the synchroniser vector
// ----------------------------------------
`define PIN_CS 0
`define PIN_SCLK 1
`define PIN_CASC 2
`define PIN_BELOW_OFF 3
`define PIN_ABOVE_ON 4
`define PIN_TEMP 5
`define PIN_MODE8 6
`define PIN_DB_LO 7
`define PIN_DB_HI 8
`define PIN_W 9

// ----------------------------------------
// frame layout and crc
// ----------------------------------------
`define FRAME_W 16
`define STOP_BIT 1'h1
`define CRC_POLY 5'h15
`endif

// File: input_serializer_pkg.sv
// shared types of the octal input serializer
// assumes nothing beyond a SystemVerilog compiler
package input_serializer_pkg;

    // ----------------------------------------
    // link state
    // ----------------------------------------
    typedef enum logic {
        LINK_IDLE,
        LINK_FRAME
    } link_state_t;

endpackage

// File: word_buffer.sv
// two-entry buffer with valid and ready on both sides
// assumes both sides run on the core clock
`timescale 1ns/1ns
module word_buffer #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] count;
    } buf_state_t;

    buf_state_t r;
    buf_state_t n;
    logic push;
    logic pop;

    // honest flags straight from the count
    assign in_ready_o = (r.count != FULL);
    assign out_valid_o = (r.count != '0);
    assign out_data_o = r.mem[r.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // pointers wrap explicitly so depth need not be a power of two
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wp] = in_data_i;
            n.wp = (r.wp == LAST) ? '0 : r.wp + 1'b1;
        end
        if (pop) begin
            n.rp = (r.rp == LAST) ? '0 : r.rp + 1'b1;
        end
        if (push && !pop) begin
            n.count = r.count + 1'b1;
        end else if (pop && !push) begin
            n.count = r.count - 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= n;
        end
    end

endmodule

// File: debounce_filter.sv
// eight-channel debounce filter with selectable tick
// assumes field inputs are asynchronous and select bits already synchronised
`timescale 1ns/1ns
`include "input_serializer_cfg.svh"
module debounce_filter #(
    parameter int unsigned TICK1_CYC = `DEB1_TICK_CYC,
    parameter int unsigned TICK2_CYC = `DEB2_TICK_CYC,
    parameter int unsigned TICK3_CYC = `DEB3_TICK_CYC
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [7:0] field_inputs_i,
    input wire logic [1:0] debounce_sel_i,
    output logic [7:0] word_o,
    output logic valid_o,
    input wire logic ready_i
);
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] samp;
        logic [14:0] tick_cnt;
        logic [7:0] cand;
        logic [7:0][1:0] cnt;
        logic [7:0] state;
        logic pend;
    } filt_state_t;

    filt_state_t r;
    filt_state_t n;
    logic [14:0] limit;
    logic tick;

    assign word_o = r.state;
    assign valid_o = r.pend;

    // tick period is one third of the selected debounce time
    always_comb begin
        case (debounce_sel_i)
            2'h1: limit = 15'(TICK1_CYC - 1);
            2'h2: limit = 15'(TICK2_CYC - 1);
            2'h3: limit = 15'(TICK3_CYC - 1);
            default: limit = '0;
        endcase
    end
    assign tick = (r.tick_cnt >= limit);

    // a channel commits only while no earlier word waits to enter the buffer,
    // so a stalled reader delays a change rather than dropping it
    always_comb begin
        n = r;
        n.s1 = field_inputs_i;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.samp = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.samp);
        n.tick_cnt = tick ? '0 : r.tick_cnt + 1'b1;
        if (r.pend && ready_i) begin
            n.pend = 1'b0;
        end
        for (int i = 0; i < 8; i++) begin
            if (debounce_sel_i == 2'h0) begin
                n.cnt[i] = '0;
                if (r.samp[i] != r.state[i] && !r.pend) begin
                    n.state[i] = r.samp[i];
                    n.pend = 1'b1;
                end
            end else if (r.samp[i] == r.state[i]) begin
                n.cnt[i] = '0;
                n.cand[i] = r.state[i];
            end else if (r.cnt[i] == `STABLE_TICKS && !r.pend) begin
                n.state[i] = r.cand[i];
                n.cnt[i] = '0;
                n.pend = 1'b1;
            end else if (tick) begin
                if (r.cand[i] != r.samp[i] || r.cnt[i] == 2'h0) begin
                    n.cand[i] = r.samp[i];
                    n.cnt[i] = 2'h1;
                end else if (r.cnt[i] != `STABLE_TICKS) begin
                    n.cnt[i] = r.cnt[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= n;
        end
    end

    // filtered channel 0 never changes before three ticks of stability
    AST_COMMIT_NEEDS_THREE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (ce_i && debounce_sel_i != 2'h0 && r.state != n.state)
            |-> (r.cnt[0] == `STABLE_TICKS || r.state[0] == n.state[0]))
        else $error("channel 0 committed before three stable ticks");

endmodule

// File: spi_master_model.sv
// serial master model, also standing in for a downstream cascaded device
// assumes the device samples select, clock and cascade with its own core clock
`timescale 1ns/1ns
module spi_master_model (
    output logic chip_sel_n_o,
    output logic serial_clk_o,
    output logic cascade_o,
    input wire logic serial_out_i
);
    // ----------------------------------------
    // idle levels: select high, clock parked low
    // ----------------------------------------
    initial begin
        chip_sel_n_o = 1'h1;
        serial_clk_o = 1'h0;
        cascade_o = 1'h0;
    end

    // ----------------------------------------
    // frame transfer
    // ----------------------------------------
    // reads n bits msb first at clock rise; the odd start offset keeps the link phase
    // away from the core clock edges
    task automatic frame(input int n, input logic [31:0] casc, output logic [31:0] word);
        word = '0;
        #13;
        chip_sel_n_o = 1'h0;
        cascade_o = casc[31];
        #320;
        for (int i = 0; i < n; i++) begin
            serial_clk_o = 1'h1;
            word = {word[30:0], serial_out_i};
            #160;
            serial_clk_o = 1'h0;
            casc = casc << 1;
            cascade_o = casc[31];
            #160;
        end
        chip_sel_n_o = 1'h1;
        // a released line must not keep showing its last value
        cascade_o = ~cascade_o;
        #320;
    endtask

    // holds select low without clocking, so the device cannot take new words
    task automatic stall(input int dur);
        #13;
        chip_sel_n_o = 1'h0;
        #dur;
        chip_sel_n_o = 1'h1;
        #320;
    endtask
endmodule

// File: tb_input_serializer.sv
// self-checking bench for the octal input serializer
// assumes the master model drives select, clock and cascade; short tick parameters
`timescale 1ns/1ns
module tb_input_serializer;
    localparam int T1 = 4;
    localparam int T2 = 6;
    localparam int T3 = 9;
    logic core_clk_i;
    logic sys_rst_i;
    logic [7:0] field;
    logic db_lo;
    logic db_hi;
    logic len8;
    logic below_off;
    logic above_on;
    logic temp;
    logic cs_n;
    logic sclk;
    logic casc;
    logic ser_out;
    logic oe;
    logic fault_n;
    logic low_flag;
    logic hot_flag;
    logic ce;
    logic [31:0] got;
    logic [7:0] base;
    int n_fail;
    int n_compared;
    int tk;

    input_serializer #(.TICK1_CYC(T1), .TICK2_CYC(T2), .TICK3_CYC(T3)) DUT (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
        .field_inputs_i(field), .debounce_sel_lo_i(db_lo), .debounce_sel_hi_i(db_hi),
        .frame_length_select_i(len8), .supply_below_off_i(below_off),
        .supply_above_on_i(above_on), .temp_alarm_i(temp), .chip_sel_n_i(cs_n),
        .serial_clk_i(sclk), .serial_cascade_in_i(casc), .serial_out_o(ser_out),
        .serial_out_oe_o(oe), .fault_n_o(fault_n), .supply_low_flag_o(low_flag),
        .over_temp_flag_o(hot_flag));

    spi_master_model m (.chip_sel_n_o(cs_n), .serial_clk_o(sclk), .cascade_o(casc),
        .serial_out_i(ser_out));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        core_clk_i = 1'h0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    // inputs set after this wait move one nanosecond after the edge, never on it
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask

    function automatic logic [4:0] crc5(input logic [7:0] d);
        logic [4:0] c;
        logic fb;
        c = 5'h00;
        for (int i = 7; i >= 0; i--) begin
            fb = c[4] ^ d[i];
            c = {c[3:0], 1'h0};
            if (fb) c = c ^ 5'h15;
        end
        return c;
    endfunction

    function automatic logic [15:0] f16(input logic [7:0] d, input logic u, input logic o);
        return {d, crc5(d), u, o, 1'h1};
    endfunction

    task automatic tally_and_finish();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // a hang is cut short and counted as a mismatch
    initial begin
        #3000000;
        n_fail++;
        tally_and_finish();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        n_fail = 0;
        n_compared = 0;
        ce = 1'h1;
        sys_rst_i = 1'h1;
        field = 8'h00;
        {db_hi, db_lo} = 2'h0;
        len8 = 1'h0;
        below_off = 1'h0;
        above_on = 1'h0;
        temp = 1'h0;
        cyc(8);
        sys_rst_i = 1'h0;
        cyc(8);
        check("reset flags", 32'h2, {low_flag, hot_flag, fault_n, oe});
        // long frame with no filtering, then cascade data after bit 16
        field = 8'ha5;
        cyc(10);
        m.frame(16, 32'h0, got);
        check("frame16", f16(8'ha5, 1'h0, 1'h0), got);
        check("released", 32'h0, {oe, ser_out});
        m.frame(24, 32'hc3000000, got);
        check("cascade16", {f16(8'ha5, 1'h0, 1'h0), 8'hc3}, got[23:0]);
        m.frame(16, 32'hffff0000, got);
        // the frame after the shifted-in ones must still show the device's own state
        m.frame(16, 32'h0, got);
        check("read only", f16(8'ha5, 1'h0, 1'h0), got);
        // short frame: inputs then straight into cascade bits
        len8 = 1'h1;
        field = 8'h3c;
        cyc(10);
        m.frame(16, 32'h5a000000, got);
        check("frame8", {8'h3c, 8'h5a}, got);
        len8 = 1'h0;
        cyc(10);
        // supply monitor hysteresis and fault output
        below_off = 1'h1;
        cyc(8);
        check("low set", 32'h4, {low_flag, fault_n, hot_flag});
        m.frame(16, 32'h0, got);
        check("low bit", f16(8'h3c, 1'h1, 1'h0), got);
        below_off = 1'h0;
        cyc(8);
        check("low held", 32'h4, {low_flag, fault_n, hot_flag});
        above_on = 1'h1;
        cyc(8);
        check("low clear", 32'h2, {low_flag, fault_n, hot_flag});
        above_on = 1'h0;
        temp = 1'h1;
        cyc(8);
        check("hot set", 32'h1, {low_flag, fault_n, hot_flag});
        m.frame(16, 32'h0, got);
        check("hot bit", f16(8'h3c, 1'h0, 1'h1), got);
        temp = 1'h0;
        cyc(8);
        check("hot clear", 32'h2, {low_flag, fault_n, hot_flag});
        // each filter code: a one-tick pulse is dropped, a held change passes late
        base = 8'h3c;
        for (int code = 1; code <= 3; code++) begin
            tk = (code == 1) ? T1 : ((code == 2) ? T2 : T3);
            {db_hi, db_lo} = code[1:0];
            cyc(10);
            field = ~base;
            cyc(tk);
            field = base;
            cyc(5 * tk + 20);
            m.frame(16, 32'h0, got);
            check("pulse dropped", f16(base, 1'h0, 1'h0), got);
            field = ~base;
            cyc(tk);
            m.frame(16, 32'h0, got);
            check("not yet", f16(base, 1'h0, 1'h0), got);
            cyc(5 * tk + 20);
            m.frame(16, 32'h0, got);
            check("held passes", f16(~base, 1'h0, 1'h0), got);
            base = ~base;
        end
        {db_hi, db_lo} = 2'h0;
        cyc(10);
        // changes while a frame holds the latch queue in the buffer, none lost
        fork
            m.stall(2000);
            begin
                cyc(5);
                check("oe in frame", 32'h1, {31'h0, oe});
                field = 8'h11;
                cyc(5);
                field = 8'h22;
                cyc(5);
                field = 8'h33;
                cyc(5);
                field = 8'h44;
            end
        join
        cyc(10);
        m.frame(16, 32'h0, got);
        check("after stall", f16(8'h44, 1'h0, 1'h0), got);
        // a low clock enable freezes the pin path, so the alarm waits for it
        ce = 1'h0;
        temp = 1'h1;
        cyc(8);
        check("enable frozen", 32'h2, {low_flag, fault_n, hot_flag});
        ce = 1'h1;
        cyc(8);
        check("enable resumed", 32'h1, {low_flag, fault_n, hot_flag});
        tally_and_finish();
    end
endmodule
